// >>> led_sink_pwm_current_ctrl_tb.sv
`include "lsp_cfg.svh"
module led_sink_pwm_current_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                      core_clk_i = 1'b0;
    logic                      rst_n_i = 1'b0;
    lsp_pkg::lsp_req_s         req;
    logic                      ptr_load;
    logic [7:0]                rdata;
    logic [7:0]                ptr;
    logic [11:0]               opn = '0;
    logic [11:0]               sht = '0;
    logic [11:0]               snk;
    lsp_pkg::lsp_sink_s [11:0] ctl;
    logic                      busy;
    logic                      rd_d = 1'b0;
    logic [7:0]                exp_q[$];
    logic [7:0]                sc[$];
    logic [7:0]                ra[10] = '{8'h00, 8'h01, 8'h02, 8'h0E, 8'h61,
                                          8'h62, 8'h63, 8'h68, 8'h69, 8'h6E};
    int                        fail_count = 0;
    int                        n_checks = 0;
    int                        n;
    int                        hi;

    // Free-running 100 MHz clock.
    always #5 core_clk_i = ~core_clk_i;

    // Short detect and spread counts keep the run brief.
    lsp_core #(.DETECT_CYC(16), .SPREAD_CYC(64)) i_lsp_core (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .req_i(req), .ptr_load_i(ptr_load),
        .rdata_o(rdata), .ptr_o(ptr), .open_sense_i(opn), .short_sense_i(sht),
        .sink_channel_o(snk), .sink_ctrl_o(ctl), .detect_busy_o(busy));
    lsp_host i_lsp_host (.clk_i(core_clk_i), .req_o(req), .ptr_load_o(ptr_load));

    // Comparisons for bytes and for wider counts.
    task automatic chk_b(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Read data is compared one cycle after the strobe, against the oldest note.
    always @(posedge core_clk_i) begin
        rd_d <= req.rd;
        if (rd_d) begin
            chk_b(rdata, exp_q.pop_front());
        end
    end

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        i_lsp_host.rd(a);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Waits for the next rise of channel one, counting cycles and on-cycles.
    task automatic rise();
        logic p;
        p = 1'b1;
        hi = 0;
        for (n = 0; !(snk[0] === 1'b1 && p === 1'b0); n++) begin
            p = snk[0];
            @(negedge core_clk_i);
            hi += (snk[0] === 1'b1) ? 1 : 0;
            if (n > 60000) begin
                fail_count++;
                wrap_up();
            end
        end
    endtask

    // Runs one detection pass and reads its result pair and the trigger bits.
    task automatic det(input logic [7:0] v, input logic [11:0] f, input logic [7:0] lo);
        int k;
        logic seen;
        i_lsp_host.wr(8'h61, '{v});
        seen = 1'b0;
        for (k = 0; k < 200 && !(seen && busy === 1'b0); k++) begin
            @(negedge core_clk_i);
            seen |= busy === 1'b1;
        end
        if (k == 200) begin
            fail_count++;
            wrap_up();
        end
        rchk(lo, {2'b00, f[5:0]});
        rchk(lo + 8'h01, {2'b00, f[11:6]});
        rchk(8'h61, v & 8'hFC);
    endtask

    // Main sequence; each step is a distinct register behaviour.
    initial begin
        int k;
        logic [7:0] d[$];
        logic [11:0] acc;
        logic [7:0] e;
        void'($urandom(32'h55ca_05d4));
        repeat (8) @(posedge core_clk_i);
        #1 rst_n_i = 1'b1;
        foreach (ra[i]) rchk(ra[i], (i == 0) ? 8'h32 : 8'h00);
        for (k = 0; k < 12; k++) sc.push_back(8'($urandom));
        d = sc;
        d.push_front(8'h40);
        i_lsp_host.wr(8'h01, d);
        chk_b(ptr, 8'h0E);
        for (k = 0; k < 12; k++) begin
            chk_b(ctl[k].global_code, 8'h40);
            chk_b(ctl[k].scale_code, sc[k]);
        end
        rchk(8'h05, sc[3]);
        i_lsp_host.wr(8'h61, '{8'h80});
        for (k = 0; k < 12; k++) chk_b(8'(ctl[k].low_div), 8'h01);
        rchk(8'h61, 8'h80);
        // Duty for every channel while still shut down, in 8-bit mode.
        d.delete();
        for (k = 0; k < 12; k++) begin
            d.push_back(8'h80);
            d.push_back(8'h08);
        end
        i_lsp_host.wr(8'h00, '{8'h72});
        i_lsp_host.wr(8'h0E, d);
        chk_b(ptr, 8'h26);
        acc = '0;
        repeat (3000) @(negedge core_clk_i) acc |= snk;
        chk_w(32'(acc), 32'h0000_0000);
        i_lsp_host.wr(8'h00, '{8'h73});
        // In 8-bit mode each rate step doubles the frame.
        for (k = 0; k < 2; k++) begin
            i_lsp_host.wr(8'h61, '{8'(k << 4)});
            rise();
            rise();
            chk_w(n, (`LSP_TICK_DIV * 256) << k);
            chk_w(hi, (`LSP_TICK_DIV * 128) << k);
        end
        // A low rate code in 12-bit mode still gives the slow frame.
        i_lsp_host.wr(8'h00, '{8'h33});
        i_lsp_host.wr(8'h61, '{8'h30});
        rise();
        rise();
        chk_w(n, `LSP_TICK_DIV * 4096);
        chk_w(hi, `LSP_TICK_DIV * 12'h880);
        // Detection runs with a low global code, as the host should set it.
        i_lsp_host.wr(8'h01, '{8'h0F});
        opn = 12'($urandom);
        sht = 12'($urandom);
        det(8'h31, opn, 8'h62);
        det(8'h36, sht, 8'h68);
        e = {2'b00, opn[5:0]};
        opn = ~opn;
        i_lsp_host.wr(8'h62, '{8'hFF});
        rchk(8'h62, e);
        i_lsp_host.wr(8'h6E, '{8'h10});
        rchk(8'h6E, 8'h10);
        repeat (4) @(posedge core_clk_i);
        chk_w(exp_q.size(), 32'h0000_0000);
        wrap_up();
    end
endmodule // led_sink_pwm_current_ctrl_tb

// >>> lsp_cfg.svh
`ifndef LSP_CFG_SVH
`define LSP_CFG_SVH
// Register offsets.
`define LSP_ADDR_CONFIG       8'h00
`define LSP_ADDR_GLOBAL       8'h01
`define LSP_ADDR_SCALE_FIRST  8'h02
`define LSP_ADDR_SCALE_LAST   8'h0D
`define LSP_ADDR_DUTY_FIRST   8'h0E
`define LSP_ADDR_DUTY_LAST    8'h25
`define LSP_ADDR_DETECT       8'h61
`define LSP_ADDR_OPEN_LO      8'h62
`define LSP_ADDR_OPEN_HI      8'h63
`define LSP_ADDR_SHORT_LO     8'h68
`define LSP_ADDR_SHORT_HI     8'h69
`define LSP_ADDR_SPREAD       8'h6E
// Field positions.
`define LSP_CFG_RES_BIT       6
`define LSP_CFG_SSD_BIT       0
`define LSP_DET_LCD_BIT       7
`define LSP_DET_RATE_HI       6
`define LSP_DET_RATE_LO       4
`define LSP_DET_MDT_HI        3
`define LSP_DET_MDT_LO        2
`define LSP_DET_SHORT_BIT     1
`define LSP_DET_OPEN_BIT      0
`define LSP_SPR_EN_BIT        4
`define LSP_DUTY_HI_MASK      8'h0F
`define LSP_RESULT_MASK       8'h3F
// Reset values.
`define LSP_RST_CONFIG        8'h32
`define LSP_RST_ZERO          8'h00
// Timing: base tick of 64 kHz x 256 steps is 16.384 MHz, near 100 MHz / 6.
`define LSP_CLK_MHZ           100
`define LSP_TICK_DIV          3'd6
`define LSP_SPREAD_US         2099
`define LSP_SPREAD_CYC        (`LSP_SPREAD_US * `LSP_CLK_MHZ)
`define LSP_DETECT_CYC        16'h1000
`endif

// >>> lsp_core.sv
`include "lsp_cfg.svh"
// Summary of operation
// - Global 8-bit code scales all channels.
// - Peak equals 48mA times global times scale.
// - Duty in low byte plus four high bits.
// - 12-bit mode: duty over 4096.
// - Resolution bit set: one duty byte.
// - Divider bit cuts peak to quarter.
// - Rates 000-011: 64..8kHz, 4kHz 12-bit.
// - Rates 100-111: 4k..500Hz both modes.
// - Detect minimum duty 6, 3, 12 percent; 12-bit mode gives 6 for the third.
// - Open trigger runs one pass, results 62h-63h.
// - Short trigger runs one pass, results 68h-69h.
// - Result registers read-only, top bits zero.
// - Spread bit modulates timing 5.6 percent.
// - Shutdown bit low keeps all sinks off.
// - Pointer advances after each data byte.
module lsp_core #(
    parameter int CHANNELS  = 12,
    parameter int SPREAD_CYC = `LSP_SPREAD_CYC,
    parameter int DETECT_CYC = `LSP_DETECT_CYC
) (
    // Clock and reset.
    input  wire logic                  core_clk_i,
    input  wire logic                  rst_n_i,
    // Register access from the serial slave, same clock.
    input  wire lsp_pkg::lsp_req_s     req_i,
    input  wire logic                  ptr_load_i,
    output logic [7:0]                 rdata_o,
    output logic [7:0]                 ptr_o,
    // Fault comparator levels from the pins.
    input  wire logic [CHANNELS-1:0]   open_sense_i,
    input  wire logic [CHANNELS-1:0]   short_sense_i,
    // Sink drive.
    output logic [CHANNELS-1:0]        sink_channel_o,
    output lsp_pkg::lsp_sink_s [CHANNELS-1:0] sink_ctrl_o,
    output logic                       detect_busy_o
);
    logic [7:0]  config_reg, global_current_level, detect_ctrl, spread_control;
    logic [7:0]  channel_current_scale [CHANNELS];
    logic [11:0] duty [CHANNELS];
    logic [CHANNELS-1:0] open_res, short_res;
    logic [7:0]  ptr;
    lsp_pkg::lsp_det_e det_state;
    logic [15:0] det_cnt;
    logic [CHANNELS-1:0] open_s1, open_s2, short_s1, short_s2;

    // Address pointer: loaded by the slave, bumps after each data byte.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) ptr <= `LSP_RST_ZERO;
        else if (ptr_load_i) ptr <= req_i.addr;
        else if (req_i.wr || req_i.rd) ptr <= ptr + 8'h01;
    end
    assign ptr_o = ptr;

    // Decode of the accessed address, relative to the channel blocks.
    wire [7:0] scale_idx = ptr - `LSP_ADDR_SCALE_FIRST;
    wire [7:0] duty_off  = ptr - `LSP_ADDR_DUTY_FIRST;
    wire [7:0] duty_idx  = {1'b0, duty_off[7:1]};
    wire in_scale = (ptr >= `LSP_ADDR_SCALE_FIRST) && (ptr <= `LSP_ADDR_SCALE_LAST);
    wire in_duty  = (ptr >= `LSP_ADDR_DUTY_FIRST) && (ptr <= `LSP_ADDR_DUTY_LAST);
    wire wr_en    = req_i.wr && !ptr_load_i;
    wire res8     = config_reg[`LSP_CFG_RES_BIT];

    // Control registers; triggers self-clear when the pass is accepted.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            config_reg           <= `LSP_RST_CONFIG;
            global_current_level <= `LSP_RST_ZERO;
            detect_ctrl          <= `LSP_RST_ZERO;
            spread_control       <= `LSP_RST_ZERO;
        end else begin
            if (wr_en && ptr == `LSP_ADDR_CONFIG) config_reg <= req_i.wdata;
            if (wr_en && ptr == `LSP_ADDR_GLOBAL) global_current_level <= req_i.wdata;
            if (wr_en && ptr == `LSP_ADDR_SPREAD) spread_control <= req_i.wdata;
            if (wr_en && ptr == `LSP_ADDR_DETECT) detect_ctrl <= req_i.wdata;
            else if (det_state != lsp_pkg::LSP_IDLE)
                detect_ctrl[`LSP_DET_SHORT_BIT:`LSP_DET_OPEN_BIT] <= 2'b00;
        end
    end

    // Per-channel scale and duty storage.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < CHANNELS; i++) begin
                channel_current_scale[i] <= `LSP_RST_ZERO;
                duty[i] <= 12'h000;
            end
        end else if (wr_en) begin
            if (in_scale) channel_current_scale[scale_idx[3:0]] <= req_i.wdata;
            if (in_duty && !duty_off[0]) duty[duty_idx[3:0]][7:0] <= req_i.wdata;
            if (in_duty && duty_off[0])
                duty[duty_idx[3:0]][11:8] <= req_i.wdata[3:0];
        end
    end

    // Spread: two-level offset of the tick divider, stretched in the second half of the spread cycle.
    logic [31:0] spr_cnt;
    wire spr_en = spread_control[`LSP_SPR_EN_BIT];
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) spr_cnt <= 32'h0000_0000;
        else if (!spr_en || spr_cnt == 32'(SPREAD_CYC - 1)) spr_cnt <= 32'h0000_0000;
        else spr_cnt <= spr_cnt + 32'h0000_0001;
    end
    // Second half of the cycle stretches the tick by one clock in three (about 5.6 %).
    wire spr_slow = spr_en && (spr_cnt >= 32'(SPREAD_CYC / 2));
    logic [2:0] tick_div;
    logic [1:0] stretch;
    wire [2:0] div_top = (spr_slow && stretch == 2'd0) ? `LSP_TICK_DIV : (`LSP_TICK_DIV - 3'd1);
    wire tick = (tick_div == div_top);
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tick_div <= 3'd0;
            stretch  <= 2'd0;
        end else begin
            tick_div <= tick ? 3'd0 : tick_div + 3'd1;
            if (tick) stretch <= (stretch == 2'd2) ? 2'd0 : stretch + 2'd1;
        end
    end

    // Prescale: 8-bit mode runs 256 ticks per period scaled by the rate field.
    wire [2:0] rate = detect_ctrl[`LSP_DET_RATE_HI:`LSP_DET_RATE_LO];
    wire [2:0] shift = res8 ? rate : ((rate[2]) ? (rate - 3'd4) : 3'd0);
    logic [7:0] pre;
    logic [11:0] phase;
    wire [7:0] pre_top = (8'h01 << shift) - 8'h01;
    wire step = tick && (pre >= pre_top);
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pre   <= 8'h00;
            phase <= 12'h000;
        end else if (tick) begin
            pre <= step ? 8'h00 : pre + 8'h01;
            if (step) phase <= res8 ? {4'h0, phase[7:0] + 8'h01} : phase + 12'h001;
        end
    end

    // Detect minimum duty floor expressed on the 8-bit scale.
    wire [1:0] detect_min_duty = detect_ctrl[`LSP_DET_MDT_HI:`LSP_DET_MDT_LO];
    wire [7:0] floor8 = detect_min_duty[1] ? (res8 ? 8'h1F : 8'h0F) : (detect_min_duty[0] ? 8'h08 : 8'h0F);
    wire detecting = (det_state != lsp_pkg::LSP_IDLE);
    wire ssd_on = config_reg[`LSP_CFG_SSD_BIT];

    // Channel compare and sink control words.
    always_comb begin
        for (int i = 0; i < CHANNELS; i++) begin
            logic [11:0] d;
            d = res8 ? {4'h0, duty[i][7:0]} : duty[i];
            if (detecting && res8 && d[7:0] < floor8) d = {4'h0, floor8};
            if (detecting && !res8 && d < {floor8, 4'h0}) d = {floor8, 4'h0};
            sink_channel_o[i] = ssd_on && (phase < d);
            sink_ctrl_o[i].on = ssd_on;
            sink_ctrl_o[i].global_code = global_current_level;
            sink_ctrl_o[i].scale_code  = channel_current_scale[i];
            sink_ctrl_o[i].low_div = detect_ctrl[`LSP_DET_LCD_BIT];
        end
    end

    // Fault sense synchronisers.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            open_s1  <= '0;
            open_s2  <= '0;
            short_s1 <= '0;
            short_s2 <= '0;
        end else begin
            open_s1  <= open_sense_i;
            open_s2  <= open_s1;
            short_s1 <= short_sense_i;
            short_s2 <= short_s1;
        end
    end

    // One-shot detection pass; open has priority if both triggers are set.
    wire trig_open  = detect_ctrl[`LSP_DET_OPEN_BIT];
    wire trig_short = detect_ctrl[`LSP_DET_SHORT_BIT];
    wire det_done   = detecting && (det_cnt == 16'(DETECT_CYC - 1));
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            det_state <= lsp_pkg::LSP_IDLE;
            det_cnt   <= 16'h0000;
            open_res  <= '0;
            short_res <= '0;
        end else begin
            case (det_state)
                lsp_pkg::LSP_IDLE: begin
                    det_cnt <= 16'h0000;
                    if (trig_open) det_state <= lsp_pkg::LSP_OPEN;
                    else if (trig_short) det_state <= lsp_pkg::LSP_SHORT;
                end
                lsp_pkg::LSP_OPEN: begin
                    det_cnt <= det_cnt + 16'h0001;
                    if (det_done) begin
                        open_res  <= open_s2;
                        det_state <= lsp_pkg::LSP_IDLE;
                    end
                end
                lsp_pkg::LSP_SHORT: begin
                    det_cnt <= det_cnt + 16'h0001;
                    if (det_done) begin
                        short_res <= short_s2;
                        det_state <= lsp_pkg::LSP_IDLE;
                    end
                end
                default: det_state <= lsp_pkg::LSP_IDLE;
            endcase
        end
    end
    assign detect_busy_o = detecting;

    // Read mux; duty registers are write-only and read as zero.
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        case (ptr)
            `LSP_ADDR_CONFIG:   rd_mux = config_reg;
            `LSP_ADDR_GLOBAL:   rd_mux = global_current_level;
            `LSP_ADDR_DETECT:   rd_mux = detect_ctrl;
            `LSP_ADDR_OPEN_LO:  rd_mux = {2'b00, open_res[5:0]};
            `LSP_ADDR_OPEN_HI:  rd_mux = {2'b00, open_res[11:6]};
            `LSP_ADDR_SHORT_LO: rd_mux = {2'b00, short_res[5:0]};
            `LSP_ADDR_SHORT_HI: rd_mux = {2'b00, short_res[11:6]};
            `LSP_ADDR_SPREAD:   rd_mux = spread_control;
            default: if (in_scale) rd_mux = channel_current_scale[scale_idx[3:0]];
        endcase
    end
    // Read data registered so the slave shifts a stable byte.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) rdata_o <= 8'h00;
        else if (req_i.rd) rdata_o <= rd_mux;
    end


    // Shutdown checks.
    // No sink may conduct while the shutdown bit is low, whatever the duty says.
    a_sink_off_shut: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !ssd_on |-> sink_channel_o == '0)
        else $error("sink on in shutdown");

    // The analog enable follows the shutdown bit directly.
    a_ctrl_on_shut: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        sink_ctrl_o[0].on == ssd_on)
        else $error("sink enable wrong");

    // Pointer checks.
    // A data byte moves the pointer on by one register.
    a_ptr_advance: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (req_i.wr && !ptr_load_i) |=> ptr == $past(ptr) + 8'h01)
        else $error("no advance");

    // The address byte sets the pointer exactly.
    a_ptr_load: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        ptr_load_i |=> ptr == $past(req_i.addr))
        else $error("pointer not loaded");

    // Register write checks.
    // A global code write reaches the first channel's sink control word on the next cycle.
    a_global_code: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (wr_en && ptr == `LSP_ADDR_GLOBAL) |=> sink_ctrl_o[0].global_code == $past(req_i.wdata))
        else $error("global code lost");

    // The first scale register belongs to the first channel.
    a_scale_write: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (wr_en && ptr == `LSP_ADDR_SCALE_FIRST)
        |=> sink_ctrl_o[0].scale_code == $past(req_i.wdata))
        else $error("scale code lost");

    // Even duty address fills the low byte of the first channel.
    a_duty_low: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (wr_en && ptr == `LSP_ADDR_DUTY_FIRST) |=> duty[0][7:0] == $past(req_i.wdata))
        else $error("duty low byte lost");

    // Odd duty address fills only the high nibble; the top four data bits are dropped.
    a_duty_high: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (wr_en && ptr == (`LSP_ADDR_DUTY_FIRST + 8'h01))
        |=> duty[0][11:8] == $past(req_i.wdata[3:0]))
        else $error("duty high nibble lost");

    // Result register checks.
    // The unused top bits of the lower open result byte always read as zero.
    a_result_top: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        req_i.rd && (ptr == `LSP_ADDR_OPEN_LO) |=> rdata_o[7:6] == 2'b00)
        else $error("top bits");

    // Same for the upper short result byte.
    a_short_top: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        req_i.rd && (ptr == `LSP_ADDR_SHORT_HI) |=> rdata_o[7:6] == 2'b00)
        else $error("short top bits");

    // A host write to an open result address outside a pass must not disturb the stored open results.
    a_result_ro: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (wr_en && !detecting && (ptr == `LSP_ADDR_OPEN_LO || ptr == `LSP_ADDR_OPEN_HI))
        |=> $stable(open_res))
        else $error("result written");

    // Detection pass checks.
    // A pass lasts long enough for the sense levels to settle through the synchroniser.
    a_pass_length: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        $rose(detecting) |-> detecting [*8])
        else $error("pass too short");

    // An open trigger seen in idle starts an open pass.
    a_open_start: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (det_state == lsp_pkg::LSP_IDLE && trig_open) |=> det_state == lsp_pkg::LSP_OPEN)
        else $error("open pass not started");

    // A short trigger alone starts a short pass.
    a_short_start: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (det_state == lsp_pkg::LSP_IDLE && !trig_open && trig_short)
        |=> det_state == lsp_pkg::LSP_SHORT)
        else $error("short pass not started");

    // Triggers are one-shot: they drop once a pass is running, unless rewritten.
    a_trig_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (detecting && !(wr_en && ptr == `LSP_ADDR_DETECT))
        |=> detect_ctrl[`LSP_DET_SHORT_BIT:`LSP_DET_OPEN_BIT] == 2'b00)
        else $error("trigger not cleared");

    // A finished pass always returns to idle, so it runs only once.
    a_det_return: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        det_done |=> det_state == lsp_pkg::LSP_IDLE)
        else $error("pass did not end");

    // The open result takes the synchronised sense levels at the end of the pass.
    a_open_latch: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (det_state == lsp_pkg::LSP_OPEN && det_done) |=> open_res == $past(open_s2))
        else $error("open result wrong");

    // The short result does the same for the short sense levels.
    a_short_latch: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (det_state == lsp_pkg::LSP_SHORT && det_done) |=> short_res == $past(short_s2))
        else $error("short result wrong");

    // Current and timing checks.
    // The divider bit goes straight to the analog control word.
    a_low_div: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        sink_ctrl_o[0].low_div == detect_ctrl[`LSP_DET_LCD_BIT])
        else $error("divider");

    // Ticks are never closer than the base divider, even while spreading.
    a_tick_gap: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        tick |=> !tick [*5])
        else $error("tick too early");

    // With spreading off the modulation counter stays at rest.
    a_spread_off: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !spr_en |=> spr_cnt == 32'h0000_0000)
        else $error("spread running");

    // Main scenarios worth seeing at least once.
    c_open_pass: cover property (@(posedge core_clk_i) det_state == lsp_pkg::LSP_OPEN && det_done);
    c_short_pass: cover property (@(posedge core_clk_i) det_state == lsp_pkg::LSP_SHORT && det_done);
    c_spread: cover property (@(posedge core_clk_i) spr_slow);
    c_sink_on: cover property (@(posedge core_clk_i) sink_channel_o[0]);
    c_low_div: cover property (@(posedge core_clk_i) sink_ctrl_o[0].low_div);
endmodule // lsp_core

// >>> lsp_host.sv
module lsp_host (
    // Clock.
    input  wire logic         clk_i,
    // Register requests toward the core.
    output lsp_pkg::lsp_req_s req_o,
    output logic              ptr_load_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // The bus starts idle, with both strobes low.
    initial begin
        req_o = '0;
        ptr_load_o = 1'b0;
    end

    // Loads the register pointer from the address byte.
    task automatic aim(input logic [7:0] a);
        @(posedge clk_i) #1;
        ptr_load_o = 1'b1;
        req_o.addr = a;
    endtask

    // Streams bytes back to back, so each one lands one register further on.
    task automatic wr(input logic [7:0] a, input logic [7:0] d[$]);
        aim(a);
        foreach (d[i]) begin
            @(posedge clk_i) #1;
            ptr_load_o = 1'b0;
            req_o.addr = ~a;
            req_o.wr = 1'b1;
            req_o.wdata = d[i];
        end
        @(posedge clk_i) #1;
        req_o.wr = 1'b0;
        req_o.wdata = ~req_o.wdata;
    endtask

    // One read strobe; the answer shows one cycle later.
    task automatic rd(input logic [7:0] a);
        aim(a);
        @(posedge clk_i) #1;
        ptr_load_o = 1'b0;
        req_o.addr = ~a;
        req_o.rd = 1'b1;
        @(posedge clk_i) #1;
        req_o.rd = 1'b0;
    endtask
endmodule // lsp_host

// >>> lsp_pkg.sv
package lsp_pkg;
    // One register bus access from the serial slave.
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lsp_req_s;
    // Per-channel analog control word handed to the current sinks.
    typedef struct packed {
        logic       on;
        logic [7:0] global_code;
        logic [7:0] scale_code;
        logic       low_div;
    } lsp_sink_s;
    typedef enum logic [1:0] {LSP_IDLE, LSP_OPEN, LSP_SHORT} lsp_det_e;
endpackage
